// ### cop_watchdog_pkg.sv
//------------------------------------------------------------------------------
// Overview of operation
// - Watchdog is a 6-bit counter stepped by carry of a 13-bit prescaler.
// - Unserviced chain overflows, raising system reset after 2^18 - 2^4 cycles.
// - Any write to the service location clears the 6-bit counter.
// - Timeout drives the external reset pin low for 32 cycles.
// - Timeout sets the watchdog cause flag in the reset cause register.
// - Service write clears prescaler bits 12 to 4, bits 3 to 0 kept.
// - Every service write restarts the timeout period with prescaler bits 3 to 0 kept.
// - Reading the service location returns the reset vector low byte.
// - Power-on logic clears the prescaler 4096 cycles after power-up.
// - Internal reset clears both prescaler and 6-bit counter.
// - Reset vector fetch clears the prescaler.
// - Disable input follows the nonvolatile configuration disable bit.
// - Timeout also sets its status event, which raises irq_o when its mask bit is set.
// - Monitor mode with high voltage on program or reset pin disables it.
// - Watchdog keeps counting and can reset during wait mode.
// - Watchdog is clocked by the crystal oscillator clock.
// - Break with high voltage on the reset pin disables the watchdog.
//------------------------------------------------------------------------------
// Purpose : Shared constants and types of the watchdog timer.
// Assumes : Crystal clock is the block clock.
// Notes   : Byte address of a register is four times its index.
//------------------------------------------------------------------------------
package cop_watchdog_pkg;

    // ----------------------------------------------------------------------
    // Counter geometry and timing
    // ----------------------------------------------------------------------
    localparam int PRESC_WIDTH    = 13;
    localparam int WDOG_WIDTH     = 6;
    localparam int TIMEOUT_CYC    = (2 ** 18) - (2 ** 4);
    localparam int PULSE_CYC      = 32;
    localparam int POR_DELAY_CYC  = 4096;
    localparam int SVC_KEEP_BITS  = 4;

    // ----------------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------------
    localparam int        ADDR_W      = 18;
    localparam int        DATA_W      = 32;
    localparam logic [15:0] IDX_STATUS  = 16'h0000;
    localparam logic [15:0] IDX_MASK    = 16'h0001;
    localparam logic [15:0] IDX_CAUSE   = 16'h0002;
    localparam logic [15:0] IDX_STATE   = 16'h0003;
    localparam logic [15:0] IDX_SERVICE = 16'hFFFF;

    // Event bits, shared by status and mask
    localparam int EV_TIMEOUT = 0;
    localparam int EV_SERVICE = 1;
    localparam int EV_W       = 2;

    // Cause and state fields
    localparam int CAUSE_WDOG_BIT = 0;
    localparam int ST_OFF_BIT     = 8;
    localparam int ST_WAIT_BIT    = 9;
    localparam int ST_POR_BIT     = 10;

    // ----------------------------------------------------------------------
    // Pin inputs from outside the clock domain
    // ----------------------------------------------------------------------
    typedef struct packed {
        logic watchdog_disable;
        logic monitor_mode;
        logic irq_program_pin_hv;
        logic reset_pin_hv;
        logic break_active;
    } pin_in_s;

    localparam int PIN_W = $bits(pin_in_s);

endpackage

// ### sync_2ff.sv
//------------------------------------------------------------------------------
// Purpose : Two flip-flop synchroniser for a bundle of level inputs.
// Assumes : Inputs are slow levels; bits are not coherent with each other.
// Notes   : First stage feeds only the second stage.
//------------------------------------------------------------------------------
`timescale 1ns/1ps
module sync_2ff #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk_sys_i,
    input  wire logic             rst_b_i,
    input  wire logic             ce_i,
    // Data
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // Two stages, frozen with the clock enable
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else if (ce_i) begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end

    assign sync_o = sync_ff;

endmodule

// ### cop_watchdog_timer.sv
//------------------------------------------------------------------------------
// Purpose : Watchdog timer with Avalon-MM registers and reset pulse output.
// Assumes : clk_sys_i is the crystal clock; reset logic outside acts on
//           sys_reset_o and drives internal_reset_i back.
// Notes   : One wait state on every bus access.
//------------------------------------------------------------------------------
`timescale 1ns/1ps
module cop_watchdog_timer
    import cop_watchdog_pkg::*;
#(
    parameter int         PRESC_W         = PRESC_WIDTH,
    parameter int         WDOG_W          = WDOG_WIDTH,
    parameter int         TIMEOUT         = TIMEOUT_CYC,
    parameter int         PULSE_LEN       = PULSE_CYC,
    parameter int         POR_DELAY       = POR_DELAY_CYC,
    parameter logic [7:0] RESET_VECTOR_LO = 8'h00
) (
    // Clock, reset, enable
    input  wire logic              clk_sys_i,
    input  wire logic              rst_b_i,
    input  wire logic              ce_i,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0] avs_address_i,
    input  wire logic              avs_read_i,
    input  wire logic              avs_write_i,
    input  wire logic [DATA_W-1:0] avs_writedata_i,
    input  wire logic [3:0]        avs_byteenable_i,
    output logic      [DATA_W-1:0] avs_readdata_o,
    output logic                   avs_waitrequest_o,
    // Asynchronous pin levels
    input  wire pin_in_s           pins_i,
    // Same-clock system signals
    input  wire logic              internal_reset_i,
    input  wire logic              vector_fetch_i,
    input  wire logic              wait_mode_i,
    // Reset outputs, reset pin is open drain
    output logic                   sys_reset_o,
    output logic                   reset_pin_o,
    output logic                   reset_pin_oe_o,
    // Event interrupt to the system controller
    output logic                   irq_o
);

    // ----------------------------------------------------------------------
    // Elaboration checks and derived constants
    // ----------------------------------------------------------------------
    localparam int TOTAL_W = PRESC_W + WDOG_W;
    localparam int PCNT_W  = $clog2(PULSE_LEN + 1);
    localparam int POR_W   = $clog2(POR_DELAY + 1);
    localparam logic [WDOG_W-1:0]  WDOG_TOP  = WDOG_W'((TIMEOUT - 1) >> PRESC_W);
    localparam logic [PRESC_W-1:0] PRESC_TOP = PRESC_W'((TIMEOUT - 1) % (2 ** PRESC_W));
    localparam logic [PRESC_W-1:0] PRESC_MAX = '1;
    localparam logic [PCNT_W-1:0]  PULSE_LD  = PCNT_W'(PULSE_LEN);
    localparam logic [POR_W-1:0]   POR_LD    = POR_W'(POR_DELAY);

    if (TIMEOUT < 1 || TIMEOUT > (2 ** TOTAL_W) || PRESC_W <= SVC_KEEP_BITS
        || PULSE_LEN < 1 || POR_DELAY < 1) begin : g_bad_param
        $error("cop_watchdog_timer: parameter values out of range");
    end

    // ----------------------------------------------------------------------
    // Decode helper
    // ----------------------------------------------------------------------
    // Word index match; low two address bits must be zero
    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                     input logic [15:0]       idx);
        reg_hit = (addr[1:0] == 2'b00) && (addr[ADDR_W-1:2] == idx);
    endfunction

    // ----------------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------------
    pin_in_s             pins_s;
    logic [PIN_W-1:0]    pins_raw;
    logic [PIN_W-1:0]    pins_sync;

    logic [PRESC_W-1:0]  presc_ff;
    logic [PRESC_W-1:0]  nxt_presc;
    logic [WDOG_W-1:0]   wdog_ff;
    logic [WDOG_W-1:0]   nxt_wdog;
    logic [PCNT_W-1:0]   pulse_cnt_ff;
    logic [POR_W-1:0]    por_cnt_ff;
    logic                por_done_ff;
    logic                por_clear;

    logic                wait_ff;
    logic [DATA_W-1:0]   rdata_ff;
    logic                req;
    logic                access;
    logic                wr_access;
    logic                service_wr;

    logic [EV_W-1:0]     status_ff;
    logic [EV_W-1:0]     nxt_status;
    logic [EV_W-1:0]     mask_ff;
    logic                cause_ff;
    logic                irq_ff;
    logic                sys_reset_ff;
    logic                pin_oe_ff;
    logic                pin_out_ff;

    logic                wd_off;
    logic                timeout_hit;
    logic                clear_all;
    logic [DATA_W-1:0]   rd_mux;

    // ----------------------------------------------------------------------
    // Pin synchronisation
    // ----------------------------------------------------------------------
    assign pins_raw = pins_i;

    sync_2ff #(
        .WIDTH     (PIN_W)
    ) u_pin_sync (
        .clk_sys_i (clk_sys_i),
        .rst_b_i   (rst_b_i),
        .ce_i      (ce_i),
        .async_i   (pins_raw),
        .sync_o    (pins_sync)
    );

    assign pins_s = pins_sync;

    // ----------------------------------------------------------------------
    // Disable and timeout decision
    // ----------------------------------------------------------------------
    // Config disable, monitor and break high-voltage cases all gate the reset
    assign wd_off = pins_s.watchdog_disable
                  | (pins_s.monitor_mode
                     & (pins_s.irq_program_pin_hv | pins_s.reset_pin_hv))
                  | (pins_s.break_active & pins_s.reset_pin_hv);

    // Wait mode does not stop the count; it is only reported
    assign timeout_hit = (wdog_ff == WDOG_TOP) && (presc_ff == PRESC_TOP)
                       && !wd_off
                       && (pulse_cnt_ff == '0);

    // Own timeout also clears, so a held-off internal reset cannot re-fire
    assign clear_all = internal_reset_i | timeout_hit;

    // ----------------------------------------------------------------------
    // Bus handshake
    // ----------------------------------------------------------------------
    assign req        = avs_read_i | avs_write_i;
    assign access     = req && !wait_ff;
    assign wr_access  = access && avs_write_i;
    // Any data value, any lane pattern counts as a service
    assign service_wr = wr_access && reg_hit(avs_address_i, IDX_SERVICE);

    // ----------------------------------------------------------------------
    // Counter chain, stepped on the crystal clock
    // ----------------------------------------------------------------------
    // Prescaler next value; clears outrank the service partial clear
    always_comb begin
        if (clear_all || por_clear || vector_fetch_i) begin
            nxt_presc = '0;
        end else if (service_wr) begin
            nxt_presc = {{(PRESC_W-SVC_KEEP_BITS){1'b0}},
                         presc_ff[SVC_KEEP_BITS-1:0]};
        end else begin
            nxt_presc = presc_ff + 1'b1;
        end
    end

    // Watchdog counter steps on prescaler carry only
    always_comb begin
        if (clear_all || service_wr) begin
            nxt_wdog = '0;
        end else if (presc_ff == PRESC_MAX) begin
            nxt_wdog = wdog_ff + 1'b1;
        end else begin
            nxt_wdog = wdog_ff;
        end
    end

    // Counter registers
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            presc_ff <= '0;
            wdog_ff  <= '0;
        end else if (ce_i) begin
            presc_ff <= nxt_presc;
            wdog_ff  <= nxt_wdog;
        end
    end

    // ----------------------------------------------------------------------
    // Power-on delay
    // ----------------------------------------------------------------------
    assign por_clear = !por_done_ff && (por_cnt_ff == POR_LD);

    // Counts once after reset release, then one prescaler clear
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            por_cnt_ff  <= '0;
            por_done_ff <= 1'b0;
        end else if (ce_i) begin
            if (por_clear) begin
                por_done_ff <= 1'b1;
            end else if (!por_done_ff) begin
                por_cnt_ff <= por_cnt_ff + 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------------
    // Reset pulse on timeout
    // ----------------------------------------------------------------------
    // Pin is driven low only; release lets the board pull it up
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pulse_cnt_ff <= '0;
            sys_reset_ff <= 1'b0;
            pin_oe_ff    <= 1'b0;
            pin_out_ff   <= 1'b0;
        end else if (ce_i) begin
            pin_out_ff <= 1'b0;
            if (timeout_hit) begin
                pulse_cnt_ff <= PULSE_LD;
                sys_reset_ff <= 1'b1;
                pin_oe_ff    <= 1'b1;
            end else if (pulse_cnt_ff > PCNT_W'(1)) begin
                pulse_cnt_ff <= pulse_cnt_ff - 1'b1;
            end else begin
                pulse_cnt_ff <= '0;
                sys_reset_ff <= 1'b0;
                pin_oe_ff    <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------------
    // Reset cause flag
    // ----------------------------------------------------------------------
    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cause_ff <= 1'b0;
        end else if (ce_i) begin
            if (timeout_hit) begin
                cause_ff <= 1'b1;
            end else if (wr_access && reg_hit(avs_address_i, IDX_CAUSE)
                         && avs_byteenable_i[0] && avs_writedata_i[CAUSE_WDOG_BIT]) begin
                cause_ff <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------------
    // Event status, mask and interrupt
    // ----------------------------------------------------------------------
    // Sticky events; a new event beats a clear of the same bit
    always_comb begin
        nxt_status = status_ff;
        if (wr_access && reg_hit(avs_address_i, IDX_STATUS) && avs_byteenable_i[0]) begin
            nxt_status = status_ff & ~avs_writedata_i[EV_W-1:0];
        end
        if (timeout_hit) begin
            nxt_status[EV_TIMEOUT] = 1'b1;
        end
        if (service_wr) begin
            nxt_status[EV_SERVICE] = 1'b1;
        end
    end

    // Status, mask and level interrupt registers
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            status_ff <= '0;
            mask_ff   <= '0;
            irq_ff    <= 1'b0;
        end else if (ce_i) begin
            status_ff <= nxt_status;
            if (wr_access && reg_hit(avs_address_i, IDX_MASK) && avs_byteenable_i[0]) begin
                mask_ff <= avs_writedata_i[EV_W-1:0];
            end
            irq_ff <= |(nxt_status & mask_ff);
        end
    end

    // ----------------------------------------------------------------------
    // Read data and wait state
    // ----------------------------------------------------------------------
    // Unmapped addresses read zero; service location gives vector low byte
    always_comb begin
        rd_mux = '0;
        if (reg_hit(avs_address_i, IDX_STATUS)) begin
            rd_mux[EV_W-1:0] = status_ff;
        end else if (reg_hit(avs_address_i, IDX_MASK)) begin
            rd_mux[EV_W-1:0] = mask_ff;
        end else if (reg_hit(avs_address_i, IDX_CAUSE)) begin
            rd_mux[CAUSE_WDOG_BIT] = cause_ff;
        end else if (reg_hit(avs_address_i, IDX_STATE)) begin
            rd_mux[WDOG_W-1:0] = wdog_ff;
            rd_mux[ST_OFF_BIT]  = wd_off;
            rd_mux[ST_WAIT_BIT] = wait_mode_i;
            rd_mux[ST_POR_BIT]  = por_done_ff;
        end else if (reg_hit(avs_address_i, IDX_SERVICE)) begin
            rd_mux[7:0] = RESET_VECTOR_LO;
        end
    end

    // One wait cycle: waitrequest drops for the single answering cycle
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wait_ff  <= 1'b1;
            rdata_ff <= '0;
        end else if (ce_i) begin
            if (req && wait_ff) begin
                wait_ff  <= 1'b0;
                rdata_ff <= avs_read_i ? rd_mux : '0;
            end else begin
                wait_ff <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------------
    assign avs_readdata_o    = rdata_ff;
    assign avs_waitrequest_o = wait_ff;
    assign sys_reset_o       = sys_reset_ff;
    assign reset_pin_o       = pin_out_ff;
    assign reset_pin_oe_o    = pin_oe_ff;
    assign irq_o             = irq_ff;

endmodule

// ### cpu_reset_model.sv
// Purpose : System reset logic and CPU beside the watchdog.
// Assumes : Acts on the rising edge of the watchdog reset request.
// Notes   : Holds internal reset 4 cycles, then one reset vector fetch.
`timescale 1ns/1ps
module cpu_reset_model (
    // Clock and reset
    input  wire logic clk_sys_i,
    input  wire logic rst_b_i,
    // Watchdog side
    input  wire logic sys_reset_i,
    output logic      internal_reset_o,
    output logic      vector_fetch_o
);
    logic [2:0] seq_ff;
    logic       prev_ff;

    // Reset sequence counter, restarted only on a new request
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            seq_ff  <= 3'h0;
            prev_ff <= 1'b0;
        end else begin
            prev_ff <= sys_reset_i;
            if (sys_reset_i && !prev_ff) begin
                seq_ff <= 3'h6;
            end else if (seq_ff != 3'h0) begin
                seq_ff <= seq_ff - 3'h1;
            end
        end
    end

    // Internal reset first, vector fetch after it ends
    assign internal_reset_o = (seq_ff >= 3'h3);
    assign vector_fetch_o   = (seq_ff == 3'h1);
endmodule

// ### cop_watchdog_timer_checker.sv
// Purpose : Port-level checks of the watchdog timer.
// Assumes : ce_i held high, so every edge counts.
// Notes   : Attached by bind at the foot of this file.
`timescale 1ns/1ps
module cop_watchdog_checker
    import cop_watchdog_pkg::*;
#(
    parameter int         TIMEOUT = TIMEOUT_CYC,
    parameter int         PULSE   = PULSE_CYC,
    parameter logic [7:0] RV      = 8'h00
) (
    input wire logic              clk_sys_i,
    input wire logic              rst_b_i,
    input wire logic [ADDR_W-1:0] avs_address_i,
    input wire logic              avs_read_i,
    input wire logic              avs_write_i,
    input wire logic [DATA_W-1:0] avs_readdata_o,
    input wire logic              avs_waitrequest_o,
    input wire pin_in_s           pins_i,
    input wire logic              internal_reset_i,
    input wire logic              sys_reset_o,
    input wire logic              reset_pin_o,
    input wire logic              reset_pin_oe_o
);
    localparam int EARLY = TIMEOUT - 20;
    localparam logic [ADDR_W-1:0] A_SVC = {IDX_SERVICE, 2'b00};
    int   since_ff;
    int   high_ff;
    logic svc_done;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    assign svc_done = avs_write_i && !avs_waitrequest_o && (avs_address_i == A_SVC);

    // Cycles since the chain was last cleared; nibble slack kept in EARLY
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            since_ff <= 0;
        end else if (svc_done || internal_reset_i || $rose(sys_reset_o)) begin
            since_ff <= 0;
        end else begin
            since_ff <= since_ff + 1;
        end
    end

    // Length of the current reset pulse
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            high_ff <= 0;
        end else begin
            high_ff <= sys_reset_o ? high_ff + 1 : 0;
        end
    end

    a_pulse_length: assert property ($fell(sys_reset_o) |-> high_ff == PULSE)
        else $error("reset pulse length wrong");
    a_pin_follows: assert property (reset_pin_oe_o == sys_reset_o)
        else $error("reset pin enable differs from reset");
    a_pin_low: assert property (reset_pin_oe_o |-> reset_pin_o == 1'b0)
        else $error("reset pin not driven low");
    a_no_early: assert property ($rose(sys_reset_o) |-> since_ff >= EARLY)
        else $error("timeout came too early");
    a_disable_quiet: assert property (pins_i.watchdog_disable [*6] |-> !$rose(sys_reset_o))
        else $error("reset while disabled");
    a_vector_read: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i == A_SVC
        |-> avs_readdata_o == {24'h000000, RV})
        else $error("service read not reset vector");
    a_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("wait request low too long");
    a_answer_next: assert property ($rose(avs_read_i) || $rose(avs_write_i) |=> !avs_waitrequest_o)
        else $error("bus answer late");

    c_timeout: cover property ($rose(sys_reset_o));
    c_service: cover property (svc_done);
    c_vector:  cover property (avs_read_i && !avs_waitrequest_o && avs_address_i == A_SVC);
endmodule

bind cop_watchdog_timer cop_watchdog_checker #(.TIMEOUT(TIMEOUT), .PULSE(PULSE_LEN), .RV(RESET_VECTOR_LO)) u_chk (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .pins_i(pins_i), .internal_reset_i(internal_reset_i),
    .sys_reset_o(sys_reset_o), .reset_pin_o(reset_pin_o), .reset_pin_oe_o(reset_pin_oe_o));

// ### cop_watchdog_timer_bench.sv
// Purpose : Self-checking bench of the watchdog timer.
// Assumes : Shortened timeout of 200 cycles, prescaler of 5 bits.
// Notes   : Random service data and gaps from a fixed seed.
`timescale 1ns/1ps
module cop_watchdog_timer_bench;
    import cop_watchdog_pkg::*;
    localparam int                TO    = 200;
    localparam logic [7:0]        RV    = 8'h5A;
    localparam logic [ADDR_W-1:0] A_SVC = {IDX_SERVICE, 2'b00};
    logic        clk_sys_i = 1'b0, rst_b_i = 1'b0, rd = 1'b0, wr = 1'b0, wmode = 1'b0;
    logic        irst, vfet, sys_rst, pin_o, pin_oe, irq, wreq;
    logic [17:0] addr = 18'h00000;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic [4:0]  modes [4] = '{5'h10, 5'h0C, 5'h0A, 5'h03};
    pin_in_s     pins = '0;
    int          bad_count = 0, cmp_count = 0, cyc = 0, pulses = 0, n, p;

    // Clock, pulse tally and hang guard
    always #4 clk_sys_i = ~clk_sys_i;
    always @(posedge sys_rst) pulses++;
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc > 20000) begin
            bad_count++;
            report_and_stop();
        end
    end

    cop_watchdog_timer #(.PRESC_W(5), .TIMEOUT(TO), .POR_DELAY(8), .RESET_VECTOR_LO(RV)) dut (
        .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .ce_i(1'b1), .avs_address_i(addr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hF),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .pins_i(pins), .internal_reset_i(irst),
        .vector_fetch_i(vfet), .wait_mode_i(wmode), .sys_reset_o(sys_rst), .reset_pin_o(pin_o),
        .reset_pin_oe_o(pin_oe), .irq_o(irq));
    cpu_reset_model model (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .sys_reset_i(sys_rst),
        .internal_reset_o(irst), .vector_fetch_o(vfet));

    // Expected values
    function automatic logic [31:0] vec_word();
        return {24'h000000, RV};
    endfunction
    function automatic logic [31:0] in_window(input int cycles);
        return {31'h0, (cycles >= TO - 16) && (cycles <= TO + 3)};
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask

    // One bus access, held until wait request is seen low
    task automatic bus(input logic w, input logic [17:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        addr <= a;
        wdat <= d;
        wr <= w;
        rd <= !w;
        do @(posedge clk_sys_i); while (wreq !== 1'b0);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        void'($urandom(9832));
        repeat (12) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        bus(1'b0, A_SVC, 32'h0);
        chk("service_read", vec_word(), q);
        bus(1'b0, 18'h00100, 32'h0);
        chk("unmapped_read", 32'h0, q);
        bus(1'b0, 18'h00004, 32'h0);
        chk("mask_reset", 32'h0, q);
        // Random services at random gaps keep the chain from overflowing
        for (int i = 0; i < 12; i++) begin
            bus(1'b1, A_SVC, $urandom());
            bus(1'b0, 18'h0000C, 32'h0);
            chk("counter_cleared", 32'h0, q & 32'h3F);
            chk("por_done", 32'h1, (q >> ST_POR_BIT) & 32'h1);
            repeat ($urandom_range(TO - 40)) @(posedge clk_sys_i);
        end
        chk("no_timeout", 32'h0, pulses);
        // Service event is masked until its mask bit is set
        chk("irq_masked", 32'h0, irq);
        bus(1'b1, 18'h00004, 32'h2);
        bus(1'b0, 18'h00004, 32'h0);
        chk("irq_unmasked", 32'h1, irq);
        bus(1'b1, 18'h00004, 32'h1);
        bus(1'b1, 18'h00000, 32'h3);
        // Overflow, plain and in wait mode
        for (int m = 0; m < 2; m++) begin
            wmode <= m[0];
            bus(1'b1, A_SVC, 32'h0);
            n = 0;
            while (sys_rst !== 1'b1) begin
                @(posedge clk_sys_i);
                n++;
            end
            p = 0;
            while (sys_rst === 1'b1) begin
                @(posedge clk_sys_i);
                p++;
            end
            chk("timeout_window", 32'h1, in_window(n));
            chk("pulse_length", PULSE_CYC, p);
            bus(1'b0, 18'h00008, 32'h0);
            chk("cause_flag", 32'h1, q & 32'h1);
            chk("irq_timeout", 32'h1, irq);
            bus(1'b0, 18'h0000C, 32'h0);
            chk("wait_bit", m, (q >> ST_WAIT_BIT) & 32'h1);
            bus(1'b1, 18'h00008, 32'h1);
            bus(1'b1, 18'h00000, 32'h3);
            bus(1'b0, 18'h00000, 32'h0);
            chk("status_cleared", 32'h0, q & 32'h1);
            chk("irq_cleared", 32'h0, irq);
        end
        // Each disabling condition holds off the reset
        for (int k = 0; k < 4; k++) begin
            n = pulses;
            pins <= modes[k];
            repeat (2 * TO) @(posedge clk_sys_i);
            chk("disabled_quiet", n, pulses);
            bus(1'b0, 18'h0000C, 32'h0);
            chk("state_off", 32'h1, (q >> ST_OFF_BIT) & 32'h1);
            bus(1'b1, A_SVC, 32'h0);
            // Let one edge pass so the next mode is not set in the same step
            pins <= '0;
            @(posedge clk_sys_i);
        end
        bus(1'b0, 18'h00008, 32'h0);
        chk("cause_quiet", 32'h0, q);
        report_and_stop();
    end
endmodule
